// file: rtl/ptc_micro_timer.sv
`default_nettype none
module ptc_micro_timer #(
	parameter int WIDTH = ptc_pkg::MICRO_W
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_active,
	input wire logic i_force,
	input wire logic [WIDTH-1:0] i_load_value,
	output logic o_tick
);
	import ptc_pkg::*;

	typedef struct packed {
		logic active;
		logic [WIDTH-1:0] count;
		logic tick;
	} ptc_micro_state_t;

	ptc_micro_state_t st_r;
	ptc_micro_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.active = i_active;
		st_nxt.tick = 1'b0;
		if (i_active && (!st_r.active || i_force))
			st_nxt.count = i_load_value;
		else if (i_active)
		begin
			if (st_r.count == '0)
			begin
				st_nxt.count = i_load_value;
				st_nxt.tick = 1'b1;
			end
			else
				st_nxt.count = st_r.count - 1'b1;
		end
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			st_r <= '0;
			st_r.count <= WIDTH'(RST_MICRO_COUNT);
		end
		else
			st_r <= st_nxt;
	end

	assign o_tick = st_r.tick;

	a_micro_start_load: assert property (@(posedge i_clock)
		disable iff (i_rst)
		i_active && !st_r.active |=>
			st_r.count == $past(i_load_value) && !o_tick)
		else $error("micro timer did not load on start");

	a_micro_force_load: assert property (@(posedge i_clock)
		disable iff (i_rst)
		i_active && st_r.active && i_force |=>
			st_r.count == $past(i_load_value) && !o_tick)
		else $error("micro timer did not reload on force");

	a_micro_zero_reload: assert property (@(posedge i_clock)
		disable iff (i_rst)
		i_active && st_r.active && !i_force && st_r.count == '0 |=>
			o_tick && st_r.count == $past(i_load_value))
		else $error("micro timer did not reload and tick at zero");
endmodule : ptc_micro_timer
`default_nettype wire

// file: rtl/ptc_pkg.sv
`default_nettype none
package ptc_pkg;
	localparam int NUM_CHAN = 4;
	localparam int NUM_BASE = 2;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 16;
	localparam int MICRO_W = 8;
	localparam int COUNT_W = 16;

	localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_CHAN_EN = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_BASE_SEL = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_MICRO_LOAD0 = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CHAN_LOAD0 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_COUNT0 = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h34;
	localparam logic [ADDR_W-1:0] OFS_MASK = 8'h38;
	localparam logic [ADDR_W-1:0] OFS_STRIDE = 8'h04;

	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_FORCE_LSB = 4;

	localparam logic [MICRO_W-1:0] RST_MICRO_LOAD = 8'h00;
	localparam logic [MICRO_W-1:0] RST_MICRO_COUNT = 8'h00;
	localparam logic [COUNT_W-1:0] RST_CHAN_LOAD = 16'h0000;
	localparam logic [COUNT_W-1:0] RST_COUNT = 16'h0000;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} ptc_bus_req_t;
endpackage : ptc_pkg
`default_nettype wire

// file: rtl/ptc_timer_core.sv
// The strobed register port and the register addresses are this design's own decisions.
`default_nettype none
module ptc_timer_core #(
	parameter int CHANS = ptc_pkg::NUM_CHAN,
	parameter int MW = ptc_pkg::MICRO_W,
	parameter int CW = ptc_pkg::COUNT_W
)(
	input wire logic i_clock,
	input wire logic i_rst,
	input wire ptc_pkg::ptc_bus_req_t i_bus,
	output logic [ptc_pkg::DATA_W-1:0] o_rdata,
	output logic [CHANS-1:0] o_trigger,
	output logic o_irq
);
	import ptc_pkg::*;

	typedef struct packed {
		logic module_en;
		logic [CHANS-1:0] chan_en;
		logic [CHANS-1:0] base_sel;
		logic [NUM_BASE-1:0][MW-1:0] micro_load;
		logic [CHANS-1:0][CW-1:0] chan_load;
		logic [CHANS-1:0][CW-1:0] count;
		logic [CHANS-1:0] chan_run;
		logic [CHANS-1:0] status;
		logic [CHANS-1:0] mask;
		logic [CHANS-1:0] trigger;
		logic [NUM_BASE-1:0] force_mt;
		logic irq;
		logic [DATA_W-1:0] rdata;
	} ptc_state_t;

	ptc_state_t st_r;
	ptc_state_t st_nxt;

	logic [CHANS-1:0] chan_active;
	logic [CHANS-1:0] tick_sel;
	logic [NUM_BASE-1:0] base_used;
	logic [NUM_BASE-1:0] mt_tick;
	logic cnt_wr;

	function automatic logic [ADDR_W-1:0] reg_addr(
		input logic [ADDR_W-1:0] base,
		input int idx
	);
		reg_addr = ADDR_W'(base + ADDR_W'(idx) * OFS_STRIDE);
	endfunction : reg_addr

	// A channel is live only with both enables set
	assign chan_active = {CHANS{st_r.module_en}} & st_r.chan_en;

	genvar g;
	generate
		for (g = 0; g < CHANS; g++)
		begin : g_sel
			assign tick_sel[g] = st_r.base_sel[g] ? mt_tick[1] : mt_tick[0];
		end
		for (g = 0; g < NUM_BASE; g++)
		begin : g_micro
			if (g == 0)
			begin : g_b0
				assign base_used[g] = |(chan_active & ~st_r.base_sel);
			end
			else
			begin : g_b1
				assign base_used[g] = |(chan_active & st_r.base_sel);
			end
			ptc_micro_timer #(
				.WIDTH(MW)
			) u_micro (
				.i_clock(i_clock),
				.i_rst(i_rst),
				.i_active(base_used[g]),
				.i_force(st_r.force_mt[g]),
				.i_load_value(st_r.micro_load[g]),
				.o_tick(mt_tick[g])
			);
		end
	endgenerate

	always_comb
	begin
		logic [CHANS-1:0] status_clr;
		logic [CHANS-1:0] timeout_set;
		logic [DATA_W-1:0] rd_val;
		status_clr = '0;
		timeout_set = '0;
		rd_val = '0;
		st_nxt = st_r;
		st_nxt.trigger = '0;
		st_nxt.force_mt = '0;
		st_nxt.rdata = '0;

		// Count registers are absent from the write decode on purpose
		if (i_bus.wr)
		begin
			if (i_bus.addr == OFS_CTRL)
			begin
				st_nxt.module_en = i_bus.wdata[CTRL_EN_BIT];
				st_nxt.force_mt = i_bus.wdata[CTRL_FORCE_LSB +: NUM_BASE];
			end
			if (i_bus.addr == OFS_CHAN_EN)
				st_nxt.chan_en = i_bus.wdata[CHANS-1:0];
			if (i_bus.addr == OFS_BASE_SEL)
				st_nxt.base_sel = i_bus.wdata[CHANS-1:0];
			if (i_bus.addr == OFS_STATUS)
				status_clr = i_bus.wdata[CHANS-1:0];
			if (i_bus.addr == OFS_MASK)
				st_nxt.mask = i_bus.wdata[CHANS-1:0];
			for (int b = 0; b < NUM_BASE; b++)
			begin
				if (i_bus.addr == reg_addr(OFS_MICRO_LOAD0, b))
					st_nxt.micro_load[b] = i_bus.wdata[MW-1:0];
			end
			for (int i = 0; i < CHANS; i++)
			begin
				if (i_bus.addr == reg_addr(OFS_CHAN_LOAD0, i))
					st_nxt.chan_load[i] = i_bus.wdata[CW-1:0];
			end
		end

		if (i_bus.rd)
		begin
			if (i_bus.addr == OFS_CTRL)
				rd_val[CTRL_EN_BIT] = st_r.module_en;
			if (i_bus.addr == OFS_CHAN_EN)
				rd_val[CHANS-1:0] = st_r.chan_en;
			if (i_bus.addr == OFS_BASE_SEL)
				rd_val[CHANS-1:0] = st_r.base_sel;
			if (i_bus.addr == OFS_STATUS)
				rd_val[CHANS-1:0] = st_r.status;
			if (i_bus.addr == OFS_MASK)
				rd_val[CHANS-1:0] = st_r.mask;
			for (int b = 0; b < NUM_BASE; b++)
			begin
				if (i_bus.addr == reg_addr(OFS_MICRO_LOAD0, b))
					rd_val[MW-1:0] = st_r.micro_load[b];
			end
			for (int i = 0; i < CHANS; i++)
			begin
				if (i_bus.addr == reg_addr(OFS_CHAN_LOAD0, i))
					rd_val[CW-1:0] = st_r.chan_load[i];
				// Whole 16-bit word in one access, no torn halves
				if (i_bus.addr == reg_addr(OFS_COUNT0, i))
					rd_val[CW-1:0] = st_r.count[i];
			end
		end
		st_nxt.rdata = rd_val;

		for (int i = 0; i < CHANS; i++)
		begin
			st_nxt.chan_run[i] = chan_active[i];
			// Start from the load value in the first active cycle, the same cycle an idle base starts
			if (chan_active[i] && !st_r.chan_run[i])
				st_nxt.count[i] = st_r.chan_load[i];
			else if (chan_active[i] && tick_sel[i])
			begin
				if (st_r.count[i] == '0)
				begin
					st_nxt.count[i] = st_r.chan_load[i];
					st_nxt.trigger[i] = 1'b1;
					timeout_set[i] = 1'b1;
				end
				else
					st_nxt.count[i] = st_r.count[i] - 1'b1;
			end
		end

		// A time-out in the clearing cycle survives the clear
		st_nxt.status = (st_r.status & ~status_clr) | timeout_set;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			st_r <= '0;
			for (int b = 0; b < NUM_BASE; b++)
				st_r.micro_load[b] <= MW'(RST_MICRO_LOAD);
			for (int i = 0; i < CHANS; i++)
			begin
				st_r.chan_load[i] <= CW'(RST_CHAN_LOAD);
				st_r.count[i] <= CW'(RST_COUNT);
			end
		end
		else
			st_r <= st_nxt;
	end

	assign o_rdata = st_r.rdata;
	assign o_trigger = st_r.trigger;
	assign o_irq = st_r.irq;

	// Helper for the write-ignore check
	always_comb
	begin
		cnt_wr = 1'b0;
		for (int i = 0; i < CHANS; i++)
		begin
			if (i_bus.wr && i_bus.addr == reg_addr(OFS_COUNT0, i))
				cnt_wr = 1'b1;
		end
	end

	default clocking cb @(posedge i_clock);
	endclocking
	default disable iff (i_rst);

	a_count_write_ignored: assert property (
		cnt_wr |=> $stable(st_r.chan_load) && $stable(st_r.chan_en) &&
			$stable(st_r.module_en) && $stable(st_r.mask) &&
			$stable(st_r.base_sel) && $stable(st_r.micro_load))
		else $error("write to count register changed state");

	a_count_read_value: assert property (
		i_bus.rd && i_bus.addr == OFS_COUNT0 |=>
			o_rdata == DATA_W'($past(st_r.count[0])))
		else $error("count read returned wrong value");

	a_chan_decrement: assert property (
		chan_active[0] && st_r.chan_run[0] && tick_sel[0] &&
			st_r.count[0] != '0 |=>
			st_r.count[0] == CW'($past(st_r.count[0]) - 1'b1))
		else $error("channel did not step on its base tick");

	a_base_select_hold: assert property (
		st_r.chan_run[1] && chan_active[1] && !tick_sel[1] |=>
			$stable(st_r.count[1]) && !o_trigger[1])
		else $error("channel moved without its selected base tick");

	a_disabled_holds: assert property (
		!chan_active[1] |=> $stable(st_r.count[1]) && !o_trigger[1])
		else $error("disabled channel changed its count");

	a_zero_reload_flag: assert property (
		chan_active[0] && st_r.chan_run[0] && tick_sel[0] &&
			st_r.count[0] == '0 |=>
			o_trigger[0] && st_r.status[0] &&
			st_r.count[0] == $past(st_r.chan_load[0]) ##1
			(!o_trigger[0] || $past(tick_sel[0])))
		else $error("channel zero did not reload and flag");

	a_rdata_idle: assert property (
		!i_bus.rd |=> o_rdata == '0)
		else $error("read data not zero outside a read");

	a_ctrl_write: assert property (
		i_bus.wr && i_bus.addr == OFS_CTRL |=>
			st_r.module_en == $past(i_bus.wdata[CTRL_EN_BIT]))
		else $error("module enable write not taken");

	a_chan_en_write: assert property (
		i_bus.wr && i_bus.addr == OFS_CHAN_EN |=>
			st_r.chan_en == $past(i_bus.wdata[CHANS-1:0]))
		else $error("channel enable write not taken");

	a_base_sel_write: assert property (
		i_bus.wr && i_bus.addr == OFS_BASE_SEL |=>
			st_r.base_sel == $past(i_bus.wdata[CHANS-1:0]))
		else $error("base select write not taken");

	a_mask_write: assert property (
		i_bus.wr && i_bus.addr == OFS_MASK |=>
			st_r.mask == $past(i_bus.wdata[CHANS-1:0]))
		else $error("mask write not taken");

	// An idle base must stay silent, or idle channels see stray ticks
	for (g = 0; g < NUM_BASE; g++)
	begin : g_base_chk
		a_base_idle_quiet: assert property (
			!base_used[g] |=> !mt_tick[g])
			else $error("unused micro time base ticked");

		a_micro_load_write: assert property (
			i_bus.wr && i_bus.addr == reg_addr(OFS_MICRO_LOAD0, g) |=>
				st_r.micro_load[g] == $past(i_bus.wdata[MW-1:0]))
			else $error("micro load write not taken");
	end

	for (g = 0; g < CHANS; g++)
	begin : g_chan_chk
		a_count_read_each: assert property (
			i_bus.rd && i_bus.addr == reg_addr(OFS_COUNT0, g) |=>
				o_rdata == DATA_W'($past(st_r.count[g])))
			else $error("count read returned wrong value");

		a_chan_load_write: assert property (
			i_bus.wr && i_bus.addr == reg_addr(OFS_CHAN_LOAD0, g) |=>
				st_r.chan_load[g] == $past(i_bus.wdata[CW-1:0]))
			else $error("channel load write not taken");

		// Re-enable restarts a full period, not a stale mid-count
		a_chan_start_load: assert property (
			chan_active[g] && !st_r.chan_run[g] |=>
				st_r.count[g] == $past(st_r.chan_load[g]) && !o_trigger[g])
			else $error("channel did not start from its load value");

		a_chan_idle_hold: assert property (
			!chan_active[g] |=> $stable(st_r.count[g]) && !o_trigger[g])
			else $error("inactive channel changed its count");

		a_chan_step_each: assert property (
			chan_active[g] && st_r.chan_run[g] && tick_sel[g] &&
				st_r.count[g] != '0 |=>
				st_r.count[g] == CW'($past(st_r.count[g]) - 1'b1))
			else $error("channel did not step on its base tick");

		a_base_hold_each: assert property (
			chan_active[g] && st_r.chan_run[g] && !tick_sel[g] |=>
				$stable(st_r.count[g]))
			else $error("channel moved without its selected base tick");

		a_trigger_cause: assert property (
			o_trigger[g] |-> $past(st_r.count[g]) == '0 &&
				st_r.status[g])
			else $error("trigger without a channel time-out");

		a_status_clear: assert property (
			i_bus.wr && i_bus.addr == OFS_STATUS && i_bus.wdata[g] &&
				!(chan_active[g] && st_r.chan_run[g] && tick_sel[g] &&
				st_r.count[g] == '0) |=> !st_r.status[g])
			else $error("status flag not cleared by write of one");
	end
endmodule : ptc_timer_core
`default_nettype wire

// file: tb/ptc_timer_core_tb_top.sv
`default_nettype none
module ptc_timer_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import ptc_pkg::*;

	logic i_clock = 1'b0;
	logic i_rst = 1'b1;
	ptc_bus_req_t bus_r = '0;
	logic [DATA_W-1:0] rdata;
	logic [NUM_CHAN-1:0] trig;
	logic irq;
	int error_cnt = 0;
	int total_checks = 0;
	int n;

	always #5 i_clock = ~i_clock;

	ptc_timer_core dut_u (
		.i_clock(i_clock),
		.i_rst(i_rst),
		.i_bus(bus_r),
		.o_rdata(rdata),
		.o_trigger(trig),
		.o_irq(irq)
	);

	task automatic complete_run();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : complete_run

	task automatic chk(input string name, input logic [15:0] exp,
		input logic [15:0] got);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Write taken at the edge after the strobe is driven
	task automatic bus_wr(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		@(posedge i_clock);
		bus_r <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clock);
		bus_r <= '0;
	endtask : bus_wr

	// Single 16-bit read; data stands one cycle only, then 0
	task automatic bus_rd(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] exp, input string name);
		@(posedge i_clock);
		bus_r <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge i_clock);
		bus_r <= '0;
		#1;
		chk(name, exp, rdata);
		@(posedge i_clock);
		#1;
		chk("rdata after read", 16'h0000, rdata);
	endtask : bus_rd

	// Bounded wait for a trigger pulse of one channel
	task automatic wait_trig(input int ch, output int cyc);
		cyc = 0;
		do
		begin
			@(posedge i_clock);
			#1;
			cyc++;
		end
		while (trig[ch] !== 1'b1 && cyc < 1000);
		if (cyc >= 1000)
		begin
			error_cnt++;
			$display("[FAIL] trigger wait expected 1 seen timeout");
			complete_run();
		end
	endtask : wait_trig

	function automatic logic [ADDR_W-1:0] cnt_ofs(input int i);
		return OFS_COUNT0 + 8'(4 * i);
	endfunction : cnt_ofs

	initial
	begin
		repeat (5) @(posedge i_clock);
		i_rst <= 1'b0;
		for (int i = 0; i < NUM_CHAN; i++)
			bus_rd(cnt_ofs(i), 16'h0000, "count at reset");
		bus_rd(OFS_STATUS, 16'h0000, "status at reset");
		chk("irq at reset", 16'h0000, {15'h0, irq});
		$display("reset test done");

		bus_wr(OFS_MICRO_LOAD0, 16'h0002);
		bus_wr(OFS_MICRO_LOAD0 + 8'h04, 16'h00ff);
		bus_wr(OFS_CHAN_LOAD0, 16'h0001);
		bus_wr(OFS_CHAN_LOAD0 + 8'h04, 16'h1234);
		bus_wr(OFS_CHAN_LOAD0 + 8'h08, 16'h0055);
		bus_wr(OFS_BASE_SEL, 16'h0002);
		bus_wr(OFS_MASK, 16'h0001);
		bus_wr(OFS_CHAN_EN, 16'h0003);
		bus_wr(OFS_CTRL, 16'h0001);
		// Slow base 1 has not ticked yet, so count stays at its load
		bus_rd(cnt_ofs(1), 16'h1234, "count1 on base1");
		bus_rd(cnt_ofs(2), 16'h0000, "count2 disabled");
		wait_trig(0, n);
		wait_trig(0, n);
		// Period is (micro load + 1) * (channel load + 1)
		chk("trigger period", 16'h0006, 16'(n));
		chk("irq on time-out", 16'h0001, {15'h0, irq});
		$display("counting test done");

		bus_rd(OFS_CHAN_LOAD0, 16'h0001, "chan load0");
		bus_rd(OFS_MICRO_LOAD0 + 8'h04, 16'h00ff, "micro load1");
		bus_rd(OFS_BASE_SEL, 16'h0002, "base select");
		bus_rd(OFS_CHAN_EN, 16'h0003, "channel enable");
		// Force both micro timers; the period must stay intact afterwards
		bus_wr(OFS_CTRL, 16'h0031);
		bus_rd(OFS_CTRL, 16'h0001, "ctrl force reads 0");
		wait_trig(0, n);
		wait_trig(0, n);
		chk("period after force", 16'h0006, 16'(n));
		$display("force load test done");

		bus_wr(OFS_CTRL, 16'h0000);
		bus_rd(cnt_ofs(1), 16'h1234, "count1 held");
		bus_wr(cnt_ofs(1), 16'hbeef);
		bus_rd(cnt_ofs(1), 16'h1234, "count1 after write");
		$display("count register test done");

		bus_rd(OFS_STATUS, 16'h0001, "status flag");
		bus_wr(OFS_MASK, 16'h0000);
		@(posedge i_clock);
		#1;
		chk("irq masked", 16'h0000, {15'h0, irq});
		bus_wr(OFS_MASK, 16'h0001);
		@(posedge i_clock);
		#1;
		chk("irq unmasked", 16'h0001, {15'h0, irq});
		bus_wr(OFS_STATUS, 16'h0001);
		bus_rd(OFS_STATUS, 16'h0000, "status cleared");
		chk("irq cleared", 16'h0000, {15'h0, irq});
		bus_rd(8'hfc, 16'h0000, "unmapped read");
		$display("interrupt test done");
		complete_run();
	end
endmodule : ptc_timer_core_tb_top
`default_nettype wire
